// ### src/ordr_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "ordr_cfg.svh"

module ordr_regs
  import ordr_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // register access from the serial engine
  input wire ordr_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // system state
  input wire logic sample_tick_i,
  input wire logic [2:0] output_sample_rate_i,
  input wire logic active_mode_i,
  input wire logic orient_irq_enable_i,
  // measurements from the datapath
  input wire logic [8:0] z_angle_deg_i,
  input wire logic [9:0] tilt_elev_x10_i,
  input wire logic [12:0] g_mag_mg_i,
  input wire logic [2:0] pl_direction_i,
  // outputs
  output logic [7:0] portrait_to_land_thresh_byte_o,
  output logic orient_irq_source_bit_o,
  output ordr_orient_t orient_o
);

  // register state
  logic [7:0] orient_config_q;
  logic [7:0] orient_debounce_reg_q;
  logic [7:0] tilt_and_face_angles_q;
  logic [7:0] portrait_to_land_thresh_a_q;
  logic orientation_change_flag_q;
  ordr_orient_t cur_q;
  ordr_orient_t prior_q;
  ordr_orient_t cand_q;
  logic [7:0] rdata_q;
  logic [2:0] rate_q;
  logic active_q;

  // decoded fields
  logic debounce_mode_bit;
  logic orient_detect_enable;
  logic [2:0] flat_threshold_offset;
  logic [1:0] face_trip_angle;
  logic [2:0] z_tilt_angle_field;

  // decision signals
  ordr_orient_t cand;
  logic [9:0] z_tilt_angle_field_lim;
  logic [9:0] z_ext;
  logic [9:0] front_lo;
  logic [9:0] front_hi;
  logic [9:0] back_lo;
  logic [9:0] back_hi;
  logic [12:0] g_limit;
  logic [12:0] g_low;
  logic in_g_window;
  logic to_front;
  logic to_back;
  logic hit;
  logic restart;
  logic abort;
  logic cand_new;
  logic done;
  logic status_read;

  // pack a reading into its register image
  function automatic logic [7:0] pack_status(input logic flag, input ordr_orient_t o);
    logic [7:0] v;
    v = `ORDR_RST_ZERO;
    v[`ORDR_ST_FLAG_BIT] = flag;
    v[`ORDR_ST_LO_BIT] = o.z_tilt_trip_flag;
    v[`ORDR_ST_PL_MSB:`ORDR_ST_PL_LSB] = o.portrait_landscape_code;
    v[`ORDR_ST_BF_MSB:`ORDR_ST_BF_LSB] = o.face_direction_code;
    return v;
  endfunction

  // register field decode
  assign debounce_mode_bit = orient_config_q[`ORDR_CFG_DBM_BIT];
  assign orient_detect_enable = orient_config_q[`ORDR_CFG_EN_BIT];
  assign flat_threshold_offset = orient_config_q[`ORDR_CFG_FLAT_THRESHOLD_OFFSET_MSB:`ORDR_CFG_FLAT_THRESHOLD_OFFSET_LSB];
  assign face_trip_angle = tilt_and_face_angles_q[`ORDR_ANG_FACE_TRIP_ANGLE_MSB:`ORDR_ANG_FACE_TRIP_ANGLE_LSB];
  assign z_tilt_angle_field = tilt_and_face_angles_q[`ORDR_ANG_Z_TILT_ANGLE_FIELD_MSB:`ORDR_ANG_Z_TILT_ANGLE_FIELD_LSB];
  assign status_read = reg_req_i.rd && (reg_req_i.addr == `ORDR_OFF_STATUS);

  // thresholds from the programmed angle codes
  assign z_tilt_angle_field_lim = `ORDR_Z_TILT_ANGLE_FIELD_BASE + 10'(z_tilt_angle_field) * `ORDR_Z_TILT_ANGLE_FIELD_STEP;
  assign front_lo = `ORDR_BF_FRONT_LO - 10'(face_trip_angle) * `ORDR_BF_STEP;
  assign front_hi = `ORDR_BF_FRONT_HI + 10'(face_trip_angle) * `ORDR_BF_STEP;
  assign back_lo = `ORDR_BF_BACK_LO + 10'(face_trip_angle) * `ORDR_BF_STEP;
  assign back_hi = `ORDR_BF_BACK_HI - 10'(face_trip_angle) * `ORDR_BF_STEP;
  assign z_ext = {1'b0, z_angle_deg_i};
  assign to_front = (z_ext < front_lo) || (z_ext > front_hi);
  assign to_back = (z_ext > back_lo) && (z_ext < back_hi);

  // 1g window, widened by 50 mg per offset step
  assign g_limit = `ORDR_ONE_G_MG + 13'(flat_threshold_offset) * `ORDR_FLAT_THRESHOLD_OFFSET_STEP_MG;
  assign g_low = (`ORDR_ONE_G_MG << 1) - g_limit;
  assign in_g_window = (g_mag_mg_i <= g_limit) && (g_mag_mg_i >= g_low);

  // candidate reading for this sample; holds current state outside the 1g window
  always_comb begin
    cand = cur_q;
    if (in_g_window) begin
      cand.z_tilt_trip_flag = (tilt_elev_x10_i < z_tilt_angle_field_lim);
      if (to_front) begin
        cand.face_direction_code = ORDR_FACE_FRONT;
      end else if (to_back) begin
        cand.face_direction_code = ORDR_FACE_BACK;
      end
      // lockout freezes the portrait/landscape code; illegal directions are ignored
      if (!cand.z_tilt_trip_flag && (pl_direction_i != ORDR_PL_UNDEF) &&
          (pl_direction_i <= ORDR_PL_LAND_LEFT)) begin
        cand.portrait_landscape_code = pl_direction_i;
      end
    end
  end

  // the candidate only counts while it differs from what is reported
  assign hit = orient_detect_enable && (cand != cur_q);
  // disable, a rate change or a mode change aborts the count and any update
  assign abort = !orient_detect_enable ||
                 (output_sample_rate_i != rate_q) ||
                 (active_mode_i != active_q);
  // a new candidate restarts the count but its own sample still counts
  assign cand_new = sample_tick_i && hit && (cand != cand_q);
  assign restart = abort || cand_new;

  ordr_debounce #(
    .CNT_W(CNT_W)
  ) u_debounce (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(restart),
    .tick_i(sample_tick_i),
    .hit_i(hit && !abort),
    .clear_mode_i(debounce_mode_bit),
    .limit_i(orient_debounce_reg_q),
    .done_o(done)
  );

  // track rate and mode to spot their changes
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rate_q <= 3'h0;
      active_q <= 1'b0;
      cand_q <= '0;
    end else begin
      rate_q <= output_sample_rate_i;
      active_q <= active_mode_i;
      if (sample_tick_i) begin
        cand_q <= cand;
      end
    end
  end

  // reported and prior readings advance only on a debounced change
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cur_q <= '0;
      prior_q <= '0;
    end else if (done) begin
      cur_q <= cand;
      prior_q <= cur_q;
    end
  end

  // change flag: a new reading in the same cycle as a read keeps the flag set
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      orientation_change_flag_q <= 1'b0;
    end else if (done) begin
      orientation_change_flag_q <= 1'b1;
    end else if (status_read) begin
      orientation_change_flag_q <= 1'b0;
    end
  end

  // software-writable registers; read-only offsets ignore writes
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      orient_config_q <= `ORDR_RST_CONFIG;
      orient_debounce_reg_q <= `ORDR_RST_DEBOUNCE;
      tilt_and_face_angles_q <= `ORDR_RST_ANGLES;
      portrait_to_land_thresh_a_q <= `ORDR_RST_THRESH_A;
    end else if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        `ORDR_OFF_CONFIG: begin
          orient_config_q <= {reg_req_i.wdata[`ORDR_CFG_DBM_BIT:`ORDR_CFG_EN_BIT], 3'h0,
                              reg_req_i.wdata[`ORDR_CFG_FLAT_THRESHOLD_OFFSET_MSB:`ORDR_CFG_FLAT_THRESHOLD_OFFSET_LSB]};
        end
        `ORDR_OFF_DEBOUNCE: begin
          orient_debounce_reg_q <= reg_req_i.wdata;
        end
        `ORDR_OFF_ANGLES: begin
          tilt_and_face_angles_q <= {reg_req_i.wdata[`ORDR_ANG_FACE_TRIP_ANGLE_MSB:`ORDR_ANG_FACE_TRIP_ANGLE_LSB], 3'h0,
                                     reg_req_i.wdata[`ORDR_ANG_Z_TILT_ANGLE_FIELD_MSB:`ORDR_ANG_Z_TILT_ANGLE_FIELD_LSB]};
        end
        `ORDR_OFF_THRESH_A: begin
          portrait_to_land_thresh_a_q <= reg_req_i.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read data registered one cycle after the request; unmapped reads give zero
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= `ORDR_RST_ZERO;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `ORDR_OFF_STATUS: rdata_q <= pack_status(orientation_change_flag_q, cur_q);
        `ORDR_OFF_PRIOR: rdata_q <= pack_status(1'b0, prior_q);
        `ORDR_OFF_CONFIG: rdata_q <= orient_config_q;
        `ORDR_OFF_DEBOUNCE: rdata_q <= orient_debounce_reg_q;
        `ORDR_OFF_ANGLES: rdata_q <= tilt_and_face_angles_q;
        `ORDR_OFF_THRESH_A: rdata_q <= portrait_to_land_thresh_a_q;
        default: rdata_q <= `ORDR_RST_ZERO;
      endcase
    end
  end

  // outputs
  assign reg_rdata_o = rdata_q;
  assign portrait_to_land_thresh_byte_o = portrait_to_land_thresh_a_q;
  assign orient_o = cur_q;
  // interrupt source follows the flag, so a status read drops it too
  assign orient_irq_source_bit_o = orientation_change_flag_q && orient_irq_enable_i;

endmodule

`default_nettype wire

// ### common/ordr_cfg.svh
`ifndef ORDR_CFG_SVH
`define ORDR_CFG_SVH

// register offsets
`define ORDR_OFF_STATUS 8'h18
`define ORDR_OFF_PRIOR 8'h19
`define ORDR_OFF_CONFIG 8'h1a
`define ORDR_OFF_DEBOUNCE 8'h1b
`define ORDR_OFF_ANGLES 8'h1c
`define ORDR_OFF_THRESH_A 8'h1d

// status field positions
`define ORDR_ST_FLAG_BIT 7
`define ORDR_ST_LO_BIT 6
`define ORDR_ST_PL_MSB 4
`define ORDR_ST_PL_LSB 2
`define ORDR_ST_BF_MSB 1
`define ORDR_ST_BF_LSB 0

// config field positions
`define ORDR_CFG_DBM_BIT 7
`define ORDR_CFG_EN_BIT 6
`define ORDR_CFG_FLAT_THRESHOLD_OFFSET_MSB 2
`define ORDR_CFG_FLAT_THRESHOLD_OFFSET_LSB 0

// angle register field positions
`define ORDR_ANG_FACE_TRIP_ANGLE_MSB 7
`define ORDR_ANG_FACE_TRIP_ANGLE_LSB 6
`define ORDR_ANG_Z_TILT_ANGLE_FIELD_MSB 2
`define ORDR_ANG_Z_TILT_ANGLE_FIELD_LSB 0

// reset values
`define ORDR_RST_CONFIG 8'h83
`define ORDR_RST_DEBOUNCE 8'h00
`define ORDR_RST_ANGLES 8'h82
`define ORDR_RST_THRESH_A 8'h1a
`define ORDR_RST_ZERO 8'h00

// angle thresholds, degrees for z, tenths of a degree for tilt
`define ORDR_BF_FRONT_LO 10'h050
`define ORDR_BF_FRONT_HI 10'h118
`define ORDR_BF_BACK_LO 10'h064
`define ORDR_BF_BACK_HI 10'h104
`define ORDR_BF_STEP 10'h005
`define ORDR_Z_TILT_ANGLE_FIELD_BASE 10'h0fa
`define ORDR_Z_TILT_ANGLE_FIELD_STEP 10'h024

// gravity magnitude window in mg
`define ORDR_ONE_G_MG 13'h03e8
`define ORDR_FLAT_THRESHOLD_OFFSET_STEP_MG 13'h0032

`endif

// ### common/ordr_pkg.sv
package ordr_pkg;

  // face direction codes
  typedef enum logic [1:0] {
    ORDR_FACE_UNDEF = 2'h0,
    ORDR_FACE_FRONT = 2'h1,
    ORDR_FACE_BACK = 2'h2
  } ordr_face_t;

  // portrait / landscape codes
  typedef enum logic [2:0] {
    ORDR_PL_UNDEF = 3'h0,
    ORDR_PL_PORT_UP = 3'h1,
    ORDR_PL_PORT_DOWN = 3'h2,
    ORDR_PL_LAND_RIGHT = 3'h3,
    ORDR_PL_LAND_LEFT = 3'h4
  } ordr_pl_t;

  // one orientation reading
  typedef struct packed {
    logic z_tilt_trip_flag;
    logic [2:0] portrait_landscape_code;
    logic [1:0] face_direction_code;
  } ordr_orient_t;

  // register access request from the serial engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ordr_req_t;

endpackage

// ### src/ordr_debounce.sv
`timescale 1ns/100ps
`default_nettype none

module ordr_debounce
  import ordr_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic hit_i,
  input wire logic clear_mode_i,
  input wire logic [CNT_W-1:0] limit_i,
  // result
  output logic done_o
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W:0] next_cnt;

  // a restart drops the old count; its own sample is the first of the new run
  assign next_cnt = clear_i ? {{CNT_W{1'b0}}, 1'b1} : ({1'b0, cnt_q} + {{CNT_W{1'b0}}, 1'b1});
  // limit of zero or one both pass on the first matching sample
  assign done_o = tick_i & hit_i & (next_cnt >= {1'b0, limit_i});

  // counter steps once per sample only
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (done_o) begin
      cnt_q <= '0;
    end else if (clear_i) begin
      cnt_q <= (tick_i && hit_i) ? next_cnt[CNT_W-1:0] : '0;
    end else if (tick_i) begin
      if (hit_i) begin
        cnt_q <= next_cnt[CNT_W-1:0];
      end else if (clear_mode_i) begin
        cnt_q <= '0;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

`default_nettype wire

// ### dv/ordr_host.sv
`timescale 1ns/100ps
`default_nettype none

module ordr_host
  import ordr_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // register port
  output var ordr_req_t req_o,
  input wire logic [7:0] rdata_i
);
  initial req_o = '0;

  // one byte written; a spare edge keeps calls apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge ref_clk_i);
    #2 req_o = '0;
    @(posedge ref_clk_i);
    #2;
  endtask

  // data is taken once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    #2 d = rdata_i;
    req_o = '0;
    @(posedge ref_clk_i);
    #2;
  endtask
endmodule

`default_nettype wire

// ### dv/ordr_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "ordr_cfg.svh"

module ordr_regs_checker
  import ordr_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire ordr_req_t reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  // system state
  input wire logic sample_tick_i,
  input wire logic [2:0] output_sample_rate_i,
  input wire logic active_mode_i,
  input wire logic orient_irq_enable_i,
  // results
  input wire logic [7:0] portrait_to_land_thresh_byte_o,
  input wire logic orient_irq_source_bit_o,
  input wire ordr_orient_t orient_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // status read with no sample racing it
  wire st_rd = reg_req_i.rd && reg_req_i.addr == `ORDR_OFF_STATUS && !sample_tick_i;

  rst_image_a: assert property ($rose(reset_n_i) |-> orient_o == '0)
    else $error("reading not cleared by reset");
  irq_gated_a: assert property (!orient_irq_enable_i |-> !orient_irq_source_bit_o)
    else $error("interrupt seen while disabled");
  change_irq_a: assert property ($changed(orient_o) && orient_irq_enable_i |->
    orient_irq_source_bit_o)
    else $error("change did not raise interrupt");
  read_clear_a: assert property (st_rd |=> !orient_irq_source_bit_o)
    else $error("status read left interrupt up");
  status_image_a: assert property (st_rd |=>
    reg_rdata_o[6:0] == {orient_o[5], 1'b0, orient_o[4:0]})
    else $error("status image wrong");
  flag_bit_a: assert property (st_rd && orient_irq_source_bit_o |=> reg_rdata_o[7])
    else $error("change flag missing in status");
  tick_only_a: assert property ($changed(orient_o) |-> $past(sample_tick_i))
    else $error("reading moved without a sample");
  rate_block_a: assert property ($changed(output_sample_rate_i) || $changed(active_mode_i) |=>
    $stable(orient_o))
    else $error("update on rate or mode change");
  codes_legal_a: assert property (orient_o[1:0] != 2'h3 && orient_o[4:2] <= 3'h4)
    else $error("illegal orientation code");
  lock_freeze_a: assert property (orient_o[5] && $past(orient_o[5]) |-> $stable(orient_o[4:2]))
    else $error("orientation moved under lockout");
  thresh_wr_a: assert property (reg_req_i.wr && reg_req_i.addr == `ORDR_OFF_THRESH_A |=>
    portrait_to_land_thresh_byte_o == $past(reg_req_i.wdata))
    else $error("threshold byte not stored");

  cover property ($changed(orient_o) && orient_o[5]);
  cover property (st_rd ##1 reg_rdata_o[7]);
  cover property ($changed(output_sample_rate_i));
endmodule

bind ordr_regs ordr_regs_checker #(.CNT_W(CNT_W)) u_chk (.ref_clk_i, .reset_n_i, .reg_req_i,
  .reg_rdata_o, .sample_tick_i, .output_sample_rate_i, .active_mode_i, .orient_irq_enable_i,
  .portrait_to_land_thresh_byte_o, .orient_irq_source_bit_o, .orient_o);

`default_nettype wire

// ### dv/ordr_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ordr_cfg.svh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) bad(n, e, a); end

module ordr_regs_tb
  import ordr_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  ordr_req_t req;
  logic [7:0] rdata, thr, d;
  logic tick = 1'b0, act = 1'b1, ien = 1'b1, irq;
  logic [2:0] rate = 3'h0, pl = 3'h0;
  logic [8:0] z = 9'h000;
  logic [9:0] tilt = 10'h384; // 90 degrees, clear of any lockout angle
  ordr_orient_t ori;
  int n_errors = 0, total_checks = 0;
  logic [7:0] adr [7] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h30};
  logic [7:0] rst [7] = '{8'h00, 8'h00, 8'h83, 8'h00, 8'h82, 8'h1a, 8'h00};
  logic [5:0] seq [3] = '{6'h29, 6'h0d, 6'h11};

  always #20 ref_clk_i = ~ref_clk_i;

  ordr_host u_host (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata));

  // gravity held at exactly 1g so the window never interferes
  ordr_regs u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .sample_tick_i(tick), .output_sample_rate_i(rate),
    .active_mode_i(act), .orient_irq_enable_i(ien), .z_angle_deg_i(z),
    .tilt_elev_x10_i(tilt), .g_mag_mg_i(`ORDR_ONE_G_MG), .pl_direction_i(pl),
    .portrait_to_land_thresh_byte_o(thr), .orient_irq_source_bit_o(irq), .orient_o(ori));

  task automatic bad(input string n, input logic [7:0] e, input logic [7:0] a);
    n_errors++;
    $display("BAD %s expected %h seen %h", n, e, a);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    `CHK("rdata", e, d)
  endtask

  // one sample strobe every other cycle
  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      @(posedge ref_clk_i);
      #2 tick = 1'b0;
      @(posedge ref_clk_i);
      #2;
    end
  endtask

  // hang guard
  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    #2 reset_n_i = 1'b1;
    for (int i = 0; i < 7; i++) rchk(adr[i], rst[i]);
    $display("test reset image done");
    u_host.wr(`ORDR_OFF_THRESH_A, 8'h20);
    `CHK("thresh", 8'h20, thr)
    u_host.wr(`ORDR_OFF_STATUS, 8'hff);
    u_host.wr(`ORDR_OFF_CONFIG, 8'h3b);
    rchk(`ORDR_OFF_STATUS, 8'h00);
    rchk(`ORDR_OFF_CONFIG, 8'h03);
    pl = 3'h1;
    ticks(2);
    `CHK("orient", 6'h00, ori)
    $display("test access and disable done");
    u_host.wr(`ORDR_OFF_CONFIG, 8'hc3);
    u_host.wr(`ORDR_OFF_DEBOUNCE, 8'h02);
    ticks(1);
    `CHK("orient", 6'h00, ori)
    ticks(1);
    `CHK("orient", 6'h05, ori)
    `CHK("irq", 1'b1, irq)
    rchk(`ORDR_OFF_STATUS, 8'h85);
    `CHK("irq", 1'b0, irq)
    rchk(`ORDR_OFF_STATUS, 8'h05);
    rchk(`ORDR_OFF_PRIOR, 8'h00);
    ien = 1'b0;
    z = 9'h0b4;
    pl = 3'h2;
    ticks(2);
    `CHK("orient", 6'h0a, ori)
    `CHK("irq", 1'b0, irq)
    ien = 1'b1;
    #2 `CHK("irq", 1'b1, irq)
    rchk(`ORDR_OFF_PRIOR, 8'h05);
    rchk(`ORDR_OFF_STATUS, 8'h8a);
    $display("test detection done");
    z = 9'h048;
    ticks(2);
    `CHK("orient", 6'h0a, ori)
    u_host.wr(`ORDR_OFF_ANGLES, 8'h02);
    ticks(2);
    `CHK("orient", 6'h09, ori)
    tilt = 10'h064;
    pl = 3'h3;
    ticks(2);
    `CHK("orient", 6'h29, ori)
    rchk(`ORDR_OFF_STATUS, 8'hc9);
    $display("test face and lockout done");
    tilt = 10'h384;
    // rate change, then standby and back, each restarts the count
    for (int k = 0; k < 2; k++) begin
      pl = 3'h3 + 3'(k);
      ticks(1);
      if (k == 0) rate = 3'h1;
      else begin
        act = 1'b0;
        ticks(1);
        act = 1'b1;
      end
      ticks(2);
      `CHK("orient", seq[k], ori)
      ticks(1);
      `CHK("orient", seq[k+1], ori)
    end
    $display("test debounce restart done");
    reset_n_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #2 reset_n_i = 1'b1;
    `CHK("orient", 6'h00, ori)
    `CHK("irq", 1'b0, irq)
    `CHK("thresh", 8'h1a, thr)
    $display("test second reset done");
    conclude();
  end
endmodule

`default_nettype wire
